// [include/crr_pkg.sv]
// Shared constants for the processor core register file
package crr_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] CRR_OFF_OPERAND = 8'h00; // Main operand register
  localparam logic [7:0] CRR_OFF_MULDIV = 8'h04; // Multiply/divide register
  localparam logic [7:0] CRR_OFF_STATUS = 8'h08; // Status word
  localparam logic [7:0] CRR_OFF_STACK = 8'h0c; // Stack top
  localparam logic [7:0] CRR_OFF_PTR_LO = 8'h10; // Selected pointer, low
  localparam logic [7:0] CRR_OFF_PTR_HI = 8'h14; // Selected pointer, high
  localparam logic [7:0] CRR_OFF_PTR_SEL = 8'h18; // Pointer select
  localparam int CRR_NUM_REGS = 7; // Mapped word count
  // Register indexes (byte offset divided by four)
  localparam logic [2:0] CRR_IDX_OPERAND = 3'h0;
  localparam logic [2:0] CRR_IDX_MULDIV = 3'h1;
  localparam logic [2:0] CRR_IDX_STATUS = 3'h2;
  localparam logic [2:0] CRR_IDX_STACK = 3'h3;
  localparam logic [2:0] CRR_IDX_PTR_LO = 3'h4;
  localparam logic [2:0] CRR_IDX_PTR_HI = 3'h5;
  localparam logic [2:0] CRR_IDX_PTR_SEL = 3'h6;
  // Status word field positions
  localparam int CRR_SW_CARRY = 7; // Carry/borrow
  localparam int CRR_SW_HALF = 6; // Nibble carry/borrow
  localparam int CRR_SW_USER0 = 5; // User flag zero
  localparam int CRR_SW_BANK_HI = 4; // Bank select high bit
  localparam int CRR_SW_BANK_LO = 3; // Bank select low bit
  localparam int CRR_SW_WRAP = 2; // Signed overflow
  localparam int CRR_SW_USER1 = 1; // User flag one
  localparam int CRR_SW_PARITY = 0; // Parity, read only
  localparam int CRR_SEL_BIT = 0; // Pointer choice bit
  // Reset values
  localparam logic [15:0] CRR_PC_RESET = 16'h0000; // Instruction counter
  localparam logic [7:0] CRR_SP_RESET = 8'h07; // Stack top
  localparam logic [7:0] CRR_SW_RESET = 8'h00; // Status word
  localparam logic [7:0] CRR_SEL_RESET = 8'h00; // Pointer select
  localparam logic [7:0] CRR_BYTE_RESET = 8'h00; // Plain data registers
  // Cycles before the boot strap is trusted after reset release
  localparam logic [1:0] CRR_BOOT_SETTLE = 2'h2;
  // Stack push sequencer states, one bit changes per step except high back to idle
  typedef enum logic [1:0] {
    CRR_PUSH_IDLE = 2'b00,
    CRR_PUSH_LOW = 2'b01,
    CRR_PUSH_HIGH = 2'b11
  } crr_push_e;
endpackage : crr_pkg

// [core/crr_stack_push.sv]
// Stack push sequencer: saves the return counter on the upward stack
`timescale 1ns/100ps
module crr_stack_push
  import crr_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic push_req, // Call or interrupt entry pulse
  input wire logic [15:0] ret_addr, // Counter value to save
  input wire logic [7:0] sp_now, // Present stack top
  output logic sp_we, // Stack top update pulse
  output logic [7:0] sp_new, // New stack top
  output logic ram_we, // Stack RAM write pulse
  output logic [7:0] ram_addr, // Stack RAM address
  output logic [7:0] ram_wdata, // Stack RAM data
  output logic busy // Push in progress
);
  crr_push_e state_reg; // Sequencer state
  crr_push_e state_next; // Next state
  logic [7:0] hi_byte_reg; // Saved high byte of the return address
  logic [7:0] sp_inc; // Stack top plus one
  logic [7:0] lo_byte_reg; // Saved low byte

  assign sp_inc = sp_now + 8'h01;
  // Each push step bumps the stack top then stores at the new top
  assign sp_we = (state_reg != CRR_PUSH_IDLE);
  assign sp_new = sp_inc;
  assign ram_we = sp_we;
  assign ram_addr = sp_inc;
  // Low byte first, high byte second
  assign ram_wdata = (state_reg == CRR_PUSH_LOW) ? lo_byte_reg :
                     hi_byte_reg;
  assign busy = sp_we;

  // Next state: idle, low, high, back to idle
  always_comb begin
    unique case (state_reg)
      CRR_PUSH_IDLE: state_next = push_req ? CRR_PUSH_LOW : CRR_PUSH_IDLE;
      CRR_PUSH_LOW: state_next = CRR_PUSH_HIGH;
      CRR_PUSH_HIGH: state_next = CRR_PUSH_IDLE;
      default: state_next = CRR_PUSH_IDLE;
    endcase
  end

  // State and captured return address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= CRR_PUSH_IDLE;
      lo_byte_reg <= CRR_BYTE_RESET;
      hi_byte_reg <= CRR_BYTE_RESET;
    end else begin
      state_reg <= state_next;
      if (push_req && (state_reg == CRR_PUSH_IDLE)) begin
        lo_byte_reg <= ret_addr[7:0];
        hi_byte_reg <= ret_addr[15:8];
      end
    end
  end
endmodule : crr_stack_push

// [core/crr_ptr_pair.sv]
// Two 16-bit data pointers sharing one address, picked by a select bit
`timescale 1ns/100ps
module crr_ptr_pair
  import crr_pkg::*;
#(
  parameter int NUM_PTR = 2 // Number of data pointers
)(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic pointer_choice, // Selected pointer
  input wire logic lo_we, // Bus write, low byte
  input wire logic hi_we, // Bus write, high byte
  input wire logic [7:0] wdata, // Bus write data
  input wire logic ptr_inc, // Core increment of selected pointer
  input wire logic ptr_load, // Core load of selected pointer
  input wire logic [15:0] ptr_value_in, // Core load value
  output logic [15:0] data_pointer // Selected pointer value
);
  logic [7:0] pointer_low_byte [NUM_PTR]; // Low byte registers
  logic [7:0] pointer_high_byte [NUM_PTR]; // High byte registers

  // Selected pointer is the one both bus and core act on
  assign data_pointer = {pointer_high_byte[pointer_choice],
                         pointer_low_byte[pointer_choice]};

  genvar g;
  generate
    for (g = 0; g < NUM_PTR; g++) begin : g_ptr
      logic mine; // This pointer is selected
      logic [15:0] cur; // Present value
      logic [15:0] inc; // Value plus one
      assign mine = (pointer_choice == 1'(g));
      assign cur = {pointer_high_byte[g], pointer_low_byte[g]};
      assign inc = cur + 16'h0001;
      // Each pointer is a high and a low byte; core beats the bus
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pointer_low_byte[g] <= CRR_BYTE_RESET;
          pointer_high_byte[g] <= CRR_BYTE_RESET;
        end else if (mine && ptr_load) begin
          pointer_low_byte[g] <= ptr_value_in[7:0];
          pointer_high_byte[g] <= ptr_value_in[15:8];
        end else if (mine && ptr_inc) begin
          pointer_low_byte[g] <= inc[7:0];
          pointer_high_byte[g] <= inc[15:8];
        end else if (mine) begin
          if (lo_we) begin
            pointer_low_byte[g] <= wdata;
          end
          if (hi_we) begin
            pointer_high_byte[g] <= wdata;
          end
        end
      end
    end
  endgenerate
endmodule : crr_ptr_pair

// [core/crr_core_regs.sv]
// Architectural register file of the 8-bit core with an AHB-Lite slave
// Behaviour
// - 16-bit instruction counter resets to 0000H
// - Alternate boot starts at second reset vector
// - Instruction counter is not bus addressable
// - Operand register feeds and takes ALU results
// - Multiply/divide register doubles as general register
// - Status bit 7 tracks carry or borrow
// - Status bit 6 tracks nibble carry
// - Status bits 4-3 select register bank
// - Status bit 2 tracks signed overflow
// - Status bit 0 is operand parity, read-only
// - Stack top resets to 07H
// - Push: bump, low byte, bump, high byte
// - Each pointer is two 8-bit halves
// - Select bit 0 picks one of two pointers
// - Select bits 7-1 read zero, ignore writes
`timescale 1ns/100ps
module crr_core_regs
  import crr_pkg::*;
#(
  parameter logic [15:0] ALT_VECTOR = 16'h0000 // Second reset vector
)(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  // AHB-Lite slave
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [31:0] hrdata, // Read data
  // Boot strap pin
  input wire logic alt_boot_en, // Start from second vector
  // Core side, same clock
  output logic core_ready, // Start vector loaded
  input wire logic pc_step, // Advance counter by one
  input wire logic pc_jump, // Load counter
  input wire logic [15:0] pc_target, // Counter load value
  output logic [15:0] instruction_counter, // Fetch address
  input wire logic operand_we, // ALU result write
  input wire logic [7:0] operand_wdata, // ALU result
  output logic [7:0] main_operand_reg, // ALU operand
  input wire logic muldiv_we, // Multiply/divide result write
  input wire logic [7:0] muldiv_wdata, // Multiply/divide result
  output logic [7:0] muldiv_reg, // Multiply/divide operand
  input wire logic flags_we, // ALU flag update
  input wire logic carry_in, // Carry or borrow
  input wire logic half_in, // Nibble carry or borrow
  input wire logic wrap_in, // Signed overflow
  output logic [7:0] status_word, // Status word with parity
  output logic [1:0] bank_select, // Active register bank
  output logic [7:0] bank_base, // First address of the bank
  input wire logic push_req, // Call or interrupt entry
  output logic push_busy, // Push in progress
  output logic [7:0] stack_top, // Stack top
  output logic stack_we, // Stack RAM write
  output logic [7:0] stack_addr, // Stack RAM address
  output logic [7:0] stack_wdata, // Stack RAM data
  input wire logic ptr_inc, // Selected pointer increment
  input wire logic ptr_load, // Selected pointer load
  input wire logic [15:0] ptr_value_in, // Pointer load value
  output logic [15:0] data_pointer, // Selected pointer
  output logic pointer_choice // Pointer in use
);
  import crr_pkg::*;

  // Decode a byte address into hit flag and register index
  function automatic logic [3:0] crr_decode(input logic [31:0] a);
    logic hit;
    hit = (a[31:5] == 27'h0) && (a[1:0] == 2'h0) &&
          (a[4:2] < 3'(CRR_NUM_REGS));
    crr_decode = {hit, a[4:2]};
  endfunction : crr_decode

  // Bus state
  logic addr_phase; // Valid address phase this cycle
  logic [3:0] ap_dec; // Decode of the address phase
  logic wr_pend_reg; // Write data phase in progress
  logic rd_pend_reg; // Read wait state in progress
  logic hit_reg; // Data phase hits a register
  logic [2:0] idx_reg; // Data phase register index
  logic [31:0] hrdata_reg; // Read data register
  logic [7:0] wbyte; // Low byte of write data
  logic wr_go; // Write commits this cycle
  // Register write strobes from the bus
  logic wr_operand; // Operand register
  logic wr_muldiv; // Multiply/divide register
  logic wr_status; // Status word
  logic wr_stack; // Stack top
  logic wr_ptr_lo; // Pointer low byte
  logic wr_ptr_hi; // Pointer high byte
  logic wr_sel; // Pointer select
  logic [7:0] rd_mux; // Read mux output
  // Architectural state
  logic [15:0] pc_reg; // Instruction counter
  logic [7:0] operand_reg; // Main operand
  logic [7:0] muldiv_r_reg; // Multiply/divide
  logic [7:1] sw_reg; // Status word, writable bits
  logic [7:0] sp_reg; // Stack top
  logic sel_reg; // Pointer choice
  logic parity; // Odd parity of the operand
  // Boot strap sync and start
  logic strap_s1_reg; // First sync stage
  logic strap_s2_reg; // Second sync stage
  logic [1:0] boot_cnt_reg; // Settle counter after release
  logic boot_done_reg; // Start vector loaded
  logic boot_load; // Load start vector this cycle
  // Push sequencer
  logic sp_push_we; // Stack top bump
  logic [7:0] sp_push_val; // Bumped value

  // Address phase is taken when selected, non-idle and bus ready
  assign addr_phase = hsel && htrans[1] && hready;
  assign ap_dec = crr_decode(haddr);
  assign wbyte = hwdata[7:0];
  assign wr_go = wr_pend_reg && hit_reg;
  assign wr_operand = wr_go && (idx_reg == CRR_IDX_OPERAND);
  assign wr_muldiv = wr_go && (idx_reg == CRR_IDX_MULDIV);
  assign wr_status = wr_go && (idx_reg == CRR_IDX_STATUS);
  assign wr_stack = wr_go && (idx_reg == CRR_IDX_STACK);
  assign wr_ptr_lo = wr_go && (idx_reg == CRR_IDX_PTR_LO);
  assign wr_ptr_hi = wr_go && (idx_reg == CRR_IDX_PTR_HI);
  assign wr_sel = wr_go && (idx_reg == CRR_IDX_PTR_SEL);

  // Read selection; no bus path reaches the instruction counter
  assign rd_mux = !hit_reg ? 8'h00 :
    (idx_reg == CRR_IDX_OPERAND) ? operand_reg :
    (idx_reg == CRR_IDX_MULDIV) ? muldiv_r_reg :
    (idx_reg == CRR_IDX_STATUS) ? status_word :
    (idx_reg == CRR_IDX_STACK) ? sp_reg :
    (idx_reg == CRR_IDX_PTR_LO) ? data_pointer[7:0] :
    (idx_reg == CRR_IDX_PTR_HI) ? data_pointer[15:8] :
    {7'h00, sel_reg};

  // Reads take one wait state so a write just before is seen
  assign hreadyout = !rd_pend_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Bus phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hit_reg <= 1'b0;
      idx_reg <= CRR_IDX_OPERAND;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      if (addr_phase) begin
        hit_reg <= ap_dec[3];
        idx_reg <= ap_dec[2:0];
      end
    end
  end

  // Read data is latched at the end of the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0;
    end else if (rd_pend_reg) begin
      hrdata_reg <= {24'h0, rd_mux};
    end
  end

  // Two-stage sync of the boot strap pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
    end else begin
      strap_s1_reg <= alt_boot_en;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Settle counter, then one load of the start vector
  assign boot_load = !boot_done_reg && (boot_cnt_reg == CRR_BOOT_SETTLE);
  assign core_ready = boot_done_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt_reg <= 2'h0;
      boot_done_reg <= 1'b0;
    end else if (!boot_done_reg) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
      boot_done_reg <= boot_load;
    end
  end

  // Instruction counter; core commands wait until the start is loaded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_reg <= CRR_PC_RESET;
    end else if (boot_load) begin
      pc_reg <= strap_s2_reg ? ALT_VECTOR : CRR_PC_RESET;
    end else if (boot_done_reg && pc_jump) begin
      pc_reg <= pc_target;
    end else if (boot_done_reg && pc_step) begin
      pc_reg <= pc_reg + 16'h0001;
    end
  end
  assign instruction_counter = pc_reg;

  // Main operand; ALU result beats a bus write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      operand_reg <= CRR_BYTE_RESET;
    end else if (operand_we) begin
      operand_reg <= operand_wdata;
    end else if (wr_operand) begin
      operand_reg <= wbyte;
    end
  end
  assign main_operand_reg = operand_reg;

  // Multiply/divide register, also free for software use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      muldiv_r_reg <= CRR_BYTE_RESET;
    end else if (muldiv_we) begin
      muldiv_r_reg <= muldiv_wdata;
    end else if (wr_muldiv) begin
      muldiv_r_reg <= wbyte;
    end
  end
  assign muldiv_reg = muldiv_r_reg;

  // Status word; ALU flags win over a bus write to the same bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_reg <= CRR_SW_RESET[7:1];
    end else begin
      if (wr_status) begin
        sw_reg <= wbyte[7:1];
      end
      if (flags_we) begin
        sw_reg[CRR_SW_CARRY] <= carry_in;
        sw_reg[CRR_SW_HALF] <= half_in;
        sw_reg[CRR_SW_WRAP] <= wrap_in;
      end
    end
  end

  // Parity follows the operand at all times; writes cannot touch it
  assign parity = ^operand_reg;
  assign status_word = {sw_reg, parity};
  assign bank_select = sw_reg[CRR_SW_BANK_HI:CRR_SW_BANK_LO];
  assign bank_base = {3'h0, bank_select, 3'h0};

  // Stack top; a push in progress beats a bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_reg <= CRR_SP_RESET;
    end else if (sp_push_we) begin
      sp_reg <= sp_push_val;
    end else if (wr_stack) begin
      sp_reg <= wbyte;
    end
  end
  assign stack_top = sp_reg;

  // Push sequencer for call and interrupt entry
  crr_stack_push u_push (
    .hclk(hclk),
    .hresetn(hresetn),
    .push_req(push_req),
    .ret_addr(pc_reg),
    .sp_now(sp_reg),
    .sp_we(sp_push_we),
    .sp_new(sp_push_val),
    .ram_we(stack_we),
    .ram_addr(stack_addr),
    .ram_wdata(stack_wdata),
    .busy(push_busy)
  );

  // Pointer select; only bit 0 is stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg <= CRR_SEL_RESET[CRR_SEL_BIT];
    end else if (wr_sel) begin
      sel_reg <= wbyte[CRR_SEL_BIT];
    end
  end
  assign pointer_choice = sel_reg;

  // Data pointer pair
  crr_ptr_pair #(
    .NUM_PTR(2)
  ) u_ptr (
    .hclk(hclk),
    .hresetn(hresetn),
    .pointer_choice(sel_reg),
    .lo_we(wr_ptr_lo),
    .hi_we(wr_ptr_hi),
    .wdata(wbyte),
    .ptr_inc(ptr_inc),
    .ptr_load(ptr_load),
    .ptr_value_in(ptr_value_in),
    .data_pointer(data_pointer)
  );

  // Transfer size is not used: every access is a whole word
  logic size_unused; // Keeps hsize read
  assign size_unused = ^hsize;
endmodule : crr_core_regs

// [tb/crr_core_regs_chk.sv]
// Concurrent checks on the core register file ports
`timescale 1ns/100ps
module crr_core_regs_chk
  import crr_pkg::*;
#(
  parameter logic [15:0] ALT_VECTOR = 16'h0000 // Second reset vector
)(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic alt_boot_en, // Boot strap
  input wire logic core_ready, // Start vector loaded
  input wire logic [15:0] instruction_counter, // Fetch address
  input wire logic flags_we, // Flag update
  input wire logic carry_in, // Carry in
  input wire logic half_in, // Nibble carry in
  input wire logic wrap_in, // Overflow in
  input wire logic [7:0] main_operand_reg, // Operand
  input wire logic [7:0] status_word, // Status word
  input wire logic [1:0] bank_select, // Bank
  input wire logic [7:0] bank_base, // Bank base
  input wire logic push_req, // Push request
  input wire logic push_busy, // Push busy
  input wire logic [7:0] stack_top, // Stack top
  input wire logic stack_we, // Stack write
  input wire logic [7:0] stack_addr, // Stack address
  input wire logic [7:0] stack_wdata, // Stack data
  input wire logic pointer_choice // Pointer in use
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read request aimed at the pointer select word
  wire rd_sel = hsel && htrans[1] && hready && !hwrite &&
    haddr == {24'h0, CRR_OFF_PTR_SEL};
  // Steps of a return address push
  sequence s_go; push_req && !push_busy; endsequence
  sequence s_low; stack_we && stack_addr == $past(stack_top) + 8'h01 &&
    stack_wdata == $past(instruction_counter[7:0]); endsequence
  sequence s_high; stack_we && stack_addr == $past(stack_top, 2) + 8'h02 &&
    stack_wdata == $past(instruction_counter[15:8], 2); endsequence
  property p_push; s_go |=> s_low ##1 s_high; endproperty
  a_push: assert property (p_push) else $error("push bytes wrong");
  property p_top; s_go |-> ##3 stack_top == $past(stack_top, 3) + 8'h02;
  endproperty
  a_top: assert property (p_top) else $error("stack top bump wrong");
  property p_parity; status_word[CRR_SW_PARITY] == ^main_operand_reg;
  endproperty
  a_parity: assert property (p_parity) else $error("parity wrong");
  property p_bank; bank_select == status_word[4:3] &&
    bank_base == {3'h0, bank_select, 3'h0}; endproperty
  a_bank: assert property (p_bank) else $error("bank wrong");
  property p_flags; flags_we |=> status_word[7] == $past(carry_in) &&
    status_word[6] == $past(half_in) && status_word[2] == $past(wrap_in);
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");
  property p_sel_rd; rd_sel |=> !hreadyout ##1
    (hreadyout && hrdata == {31'h0, pointer_choice}); endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("select read wrong");
  property p_pc_hold; !core_ready |-> instruction_counter == CRR_PC_RESET;
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("counter not zero");
  property p_boot; $rose(core_ready) |-> instruction_counter ==
    ($past(alt_boot_en, 3) ? ALT_VECTOR : CRR_PC_RESET); endproperty
  a_boot: assert property (p_boot) else $error("start vector wrong");
endmodule : crr_core_regs_chk
bind crr_core_regs crr_core_regs_chk #(.ALT_VECTOR(ALT_VECTOR)) u_chk (.*);

// [tb/cpu_core_registers_bench.sv]
// Self-checking bench for the core register file
`timescale 1ns/100ps
module cpu_core_registers_bench;
  import crr_pkg::*;
  localparam logic [15:0] ALTV = 16'h1234; // Arbitrary second vector
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, bank_select;
  logic [2:0] hsize = 3'h2; // Word transfers only
  logic hreadyout, hresp, alt_boot_en = 1'b0, core_ready, push_busy;
  logic pc_step = 1'b0, pc_jump = 1'b0, ptr_inc = 1'b0, ptr_load = 1'b0;
  logic operand_we = 1'b0, muldiv_we = 1'b0, flags_we = 1'b0;
  logic carry_in = 1'b0, half_in = 1'b0, wrap_in = 1'b0, push_req = 1'b0;
  logic stack_we, pointer_choice;
  logic [15:0] pc_target = 16'h0, ptr_value_in = 16'h0;
  logic [15:0] instruction_counter, data_pointer, pc;
  logic [7:0] operand_wdata = 8'h0, muldiv_wdata = 8'h0;
  logic [7:0] main_operand_reg, muldiv_reg, status_word, bank_base;
  logic [7:0] stack_top, stack_addr, stack_wdata;
  logic [7:0] op, md, sw, sp, sel; // Model registers
  logic [15:0] ptr [2]; // Model pointers
  int failures = 0, num_checks = 0, i;
  always #2 hclk = ~hclk;
  crr_core_regs #(.ALT_VECTOR(ALTV)) u_dut (.hready(hreadyout), .*);
  // Verdict and end of run
  task tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // Wait for hready high at an edge, bounded
  task wait_rdy(output logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    do begin
      @(negedge hclk) rdy = hreadyout;
      d = hrdata;
      @(posedge hclk);
      if (++n > 50) begin
        failures++;
        tally_and_finish();
      end
    end while (rdy !== 1'b1);
  endtask : wait_rdy
  task bus(input logic w, input int k, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, 8'(k * 4)};
    hwrite <= w;
    wait_rdy(r);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= ($urandom() << 8) | {24'h0, d}; // Upper bits are noise
    wait_rdy(r);
  endtask : bus
  function automatic logic [31:0] expv(int k);
    case (k)
      0: expv = {24'h0, op};
      1: expv = {24'h0, md};
      2: expv = {24'h0, sw[7:1], ^op};
      3: expv = {24'h0, sp};
      4: expv = {24'h0, ptr[sel[0]][7:0]};
      5: expv = {24'h0, ptr[sel[0]][15:8]};
      6: expv = {24'h0, sel};
      default: expv = 32'h0;
    endcase
  endfunction : expv
  task wr(input int k, input logic [7:0] d);
    bus(1'b1, k, d);
    case (k)
      0: op = d;
      1: md = d;
      2: sw = {d[7:1], 1'b0};
      3: sp = d;
      4: ptr[sel[0]][7:0] = d;
      5: ptr[sel[0]][15:8] = d;
      6: sel = {7'h0, d[0]};
      default: ;
    endcase
  endtask : wr
  task rd(input int k);
    bus(1'b0, k, 8'h0);
    chk("read", expv(k), r);
    chk("resp", 32'h0, {31'h0, hresp});
  endtask : rd
  // Compare every register output except the instruction counter with the model
  task cmp_ports;
    chk("status", {24'h0, sw[7:1], ^op}, {24'h0, status_word});
    chk("bank", {29'h0, sw[4:3], 1'b0}, {29'h0, bank_select, 1'b0});
    chk("base", {27'h0, sw[4:3], 3'h0}, {24'h0, bank_base});
    chk("operand", {24'h0, op}, {24'h0, main_operand_reg});
    chk("muldiv", {24'h0, md}, {24'h0, muldiv_reg});
    chk("stack", {24'h0, sp}, {24'h0, stack_top});
    chk("pointer", {16'h0, ptr[sel[0]]}, {16'h0, data_pointer});
    chk("choice", {31'h0, sel[0]}, {31'h0, pointer_choice});
  endtask : cmp_ports
  task do_reset(input logic alt);
    int n;
    hresetn <= 1'b0;
    alt_boot_en <= alt;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    {op, md, sw, sel} = 32'h0;
    sp = CRR_SP_RESET;
    ptr[0] = 16'h0;
    ptr[1] = 16'h0;
    pc = alt ? ALTV : CRR_PC_RESET;
    n = 0;
    while (core_ready !== 1'b1) begin
      @(posedge hclk);
      if (++n > 20) begin
        failures++;
        tally_and_finish();
      end
    end
    @(negedge hclk) chk("counter", {16'h0, pc}, {16'h0, instruction_counter});
    cmp_ports();
    @(posedge hclk);
  endtask : do_reset
  initial begin
    repeat (100000) @(posedge hclk);
    failures++;
    tally_and_finish();
  end
  initial begin
    r = $urandom(32'ha28be3b1);
    do_reset(1'b0);
    for (i = 0; i < 8; i++) rd(i);
    rd(16);
    // Random register traffic, unmapped word included
    repeat (60) begin
      i = $urandom_range(7);
      wr(i, 8'($urandom()));
      rd(i);
      rd(2);
      cmp_ports();
    end
    // Core side updates of operand, muldiv and flags
    repeat (30) begin
      r = $urandom();
      {flags_we, muldiv_we, operand_we} <= r[2:0];
      {wrap_in, half_in, carry_in} <= r[5:3];
      operand_wdata <= r[15:8];
      muldiv_wdata <= r[23:16];
      @(posedge hclk);
      if (r[0]) op = r[15:8];
      if (r[1]) md = r[23:16];
      if (r[2]) {sw[7], sw[6], sw[2]} = {r[3], r[4], r[5]};
      @(negedge hclk) cmp_ports();
      @(posedge hclk);
    end
    {operand_we, muldiv_we, flags_we} <= 3'h0;
    // Jump beats step, then five steps
    r = $urandom();
    pc_target <= r[15:0];
    {pc_jump, pc_step} <= 2'h3;
    @(posedge hclk) pc_jump <= 1'b0;
    repeat (5) @(posedge hclk);
    pc_step <= 1'b0;
    pc = r[15:0] + 16'h5;
    @(negedge hclk) chk("counter", {16'h0, pc}, {16'h0, instruction_counter});
    // Load beats increment on each pointer
    for (i = 0; i < 2; i++) begin
      @(posedge hclk) wr(6, 8'(i));
      r = $urandom();
      ptr_value_in <= r[15:0];
      {ptr_load, ptr_inc} <= 2'h3;
      @(posedge hclk) ptr_load <= 1'b0;
      repeat (3) @(posedge hclk);
      ptr_inc <= 1'b0;
      ptr[i] = r[15:0] + 16'h3;
      @(negedge hclk) cmp_ports();
    end
    @(posedge hclk) wr(6, 8'h0);
    rd(4);
    rd(5);
    // Push held two cycles: the second is refused
    wr(3, 8'h30);
    push_req <= 1'b1;
    @(posedge hclk);
    @(negedge hclk) chk("low", {8'h0, pc[7:0], 8'h3, 8'h31},
      {8'h0, stack_wdata, 6'h0, push_busy, stack_we, stack_addr});
    @(posedge hclk) push_req <= 1'b0;
    @(negedge hclk) chk("high", {16'h0, 8'h3, 8'h32},
      {16'h0, 6'h0, push_busy, stack_we, stack_addr});
    chk("hdata", {24'h0, pc[15:8]}, {24'h0, stack_wdata});
    repeat (2) @(posedge hclk);
    sp = 8'h32;
    @(negedge hclk) cmp_ports();
    @(posedge hclk) do_reset(1'b1);
    rd(2);
    tally_and_finish();
  end
endmodule : cpu_core_registers_bench
